// >>> src/gpiop_top.sv
// Eight-pin general-purpose I/O port with pad multiplexing and AXI4-Lite.
// Assumes the pad cell resolves value, enable and pull into the pin level.
//
// Overview of operation
// - Eight independent pins, numbered zero to seven.
// - Reset leaves every pin driver disabled.
// - Software sets each pin input or output.
// - Each pin has programmable pull-up or pull-down.
// - Undriven, disabled pin with its pull enabled takes its pull level.
// - Multiplexer gives pad to port or alternate.
// - Internal reset, overridden by external active-low reset.
// - Init latches straps, clears state, enters idle.
`timescale 1ns/100ps
module gpiop_top
  import gpiop_pkg::*;
#(
  parameter int PINS = GPIOP_PINS
)
(
  // Clock and resets
  input wire logic clk,
  input wire logic resetn,
  input wire logic ext_por_n,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pads
  input wire logic [PINS-1:0] pad_in,
  output logic [PINS-1:0] pad_out,
  output logic [PINS-1:0] pad_oe,
  output logic [PINS-1:0] pad_pull_en,
  output logic [PINS-1:0] pad_pull_up,
  // Alternate control functions sharing the pads
  input wire logic [PINS-1:0] alt_out,
  input wire logic [PINS-1:0] alt_oe,
  output logic [PINS-1:0] alt_in,
  // Strap levels sampled during initialisation
  input wire logic [PINS-1:0] strap_in,
  output logic [PINS-1:0] strap_mode,
  output logic ready
);

  // Either reset source asserts the combined reset.
  wire raw_rst_n = resetn & ext_por_n;
  logic [1:0] rst_sync_reg;
  wire rst_n = rst_sync_reg[1];

  always_ff @(posedge clk or negedge raw_rst_n)
  begin
    if (!raw_rst_n)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  // Internal power-up reset stretch, then strap latch, then idle.
  gpiop_state_t state_reg;
  gpiop_state_t state_next;
  logic [4:0] init_cnt_reg;
  logic [PINS-1:0] strap_reg;
  logic ext_seen_reg;
  logic [2*PINS-1:0] sync_q;
  wire [PINS-1:0] strap_sync = sync_q[2*PINS-1:PINS];
  wire init_done = (init_cnt_reg == 5'(GPIOP_INT_RST_CYCLES - 1));
  wire in_reset = (state_reg != GPIOP_ST_IDLE);

  always_comb
  begin
    case (state_reg)
      GPIOP_ST_RESET: state_next = init_done ? GPIOP_ST_LATCH : GPIOP_ST_RESET;
      GPIOP_ST_LATCH: state_next = GPIOP_ST_IDLE;
      GPIOP_ST_IDLE: state_next = GPIOP_ST_IDLE;
      default: state_next = GPIOP_ST_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= GPIOP_ST_RESET;
      init_cnt_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      if (!init_done)
        init_cnt_reg <= init_cnt_reg + 5'd1;
    end
  end

  // Synchronised straps are caught in the latch state; either reset clears.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_reg <= '0;
      ext_seen_reg <= 1'b0;
    end
    else if (state_reg == GPIOP_ST_LATCH)
    begin
      strap_reg <= strap_sync;
      ext_seen_reg <= 1'b1;
    end
  end

  // Control registers.
  logic [PINS-1:0] out_reg;
  logic [PINS-1:0] oe_reg;
  logic [PINS-1:0] pull_en_reg;
  logic [PINS-1:0] pull_up_reg;
  logic [PINS-1:0] alt_sel_reg;
  // Write channel: address and data taken in either order.
  logic [7:0] awaddr_reg;
  logic aw_have_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_have_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_have_reg & w_have_reg & ~bvalid_reg;
  wire [7:0] wa = awaddr_reg & 8'hfc;
  wire wr_out = do_write & (wa == GPIOP_OUT_OFS);
  wire wr_oe = do_write & (wa == GPIOP_OE_OFS);
  wire wr_pen = do_write & (wa == GPIOP_PULL_EN_OFS);
  wire wr_pup = do_write & (wa == GPIOP_PULL_UP_OFS);
  wire wr_alt = do_write & (wa == GPIOP_ALT_SEL_OFS);
  wire wr_hit = wr_out | wr_oe | wr_pen | wr_pup | wr_alt;
  wire wr_ro = (wa == GPIOP_IN_OFS) | (wa == GPIOP_STRAP_OFS) |
               (wa == GPIOP_STATUS_OFS);

  function automatic logic [PINS-1:0] merge(input logic [PINS-1:0] old,
                                           input logic [31:0] data,
                                           input logic lane0);
    merge = lane0 ? data[PINS-1:0] : old;
  endfunction

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awaddr_reg <= '0;
      aw_have_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      w_have_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= GPIOP_RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~aw_have_reg & ~aw_take & ~in_reset;
      s_axi_wready <= ~w_have_reg & ~w_take & ~in_reset;
      if (aw_take)
      begin
        awaddr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
      end
      if (w_take)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
      end
      if (do_write)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_hit | wr_ro) ? GPIOP_RESP_OKAY : GPIOP_RESP_SLVERR;
      end
      else if (bvalid_reg & s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end
    end
  end

  // Pin configuration: reset and initialisation leave every driver off.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_reg <= GPIOP_OUT_RST;
      oe_reg <= GPIOP_OE_RST;
      pull_en_reg <= GPIOP_PULL_EN_RST;
      pull_up_reg <= GPIOP_PULL_UP_RST;
      alt_sel_reg <= GPIOP_ALT_SEL_RST;
    end
    else
    begin
      if (wr_out)
        out_reg <= merge(out_reg, wdata_reg, wstrb_reg[0]);
      if (wr_oe)
        oe_reg <= merge(oe_reg, wdata_reg, wstrb_reg[0]);
      if (wr_pen)
        pull_en_reg <= merge(pull_en_reg, wdata_reg, wstrb_reg[0]);
      if (wr_pup)
        pull_up_reg <= merge(pull_up_reg, wdata_reg, wstrb_reg[0]);
      if (wr_alt)
        alt_sel_reg <= merge(alt_sel_reg, wdata_reg, wstrb_reg[0]);
    end
  end

  // One synchroniser serves every pad and every strap pin.
  wire [PINS-1:0] pin_sync = sync_q[PINS-1:0];

  gpiop_sync #(
    .WIDTH(2 * PINS)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({strap_in, pad_in}),
    .q(sync_q)
  );

  // Read channel.
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire [7:0] ra = s_axi_araddr & 8'hfc;
  wire [31:0] status_word = {30'h0, ext_seen_reg, ~in_reset};
  logic [31:0] rd_mux;
  logic rd_ok;

  always_comb
  begin
    rd_ok = 1'b1;
    case (ra)
      GPIOP_OUT_OFS: rd_mux = 32'(out_reg);
      GPIOP_OE_OFS: rd_mux = 32'(oe_reg);
      GPIOP_PULL_EN_OFS: rd_mux = 32'(pull_en_reg);
      GPIOP_PULL_UP_OFS: rd_mux = 32'(pull_up_reg);
      GPIOP_ALT_SEL_OFS: rd_mux = 32'(alt_sel_reg);
      GPIOP_IN_OFS: rd_mux = 32'(pin_sync);
      GPIOP_STRAP_OFS: rd_mux = 32'(strap_reg);
      GPIOP_STATUS_OFS: rd_mux = status_word;
      default:
      begin
        rd_mux = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= GPIOP_RESP_OKAY;
      s_axi_arready <= 1'b0;
    end
    else
    begin
      s_axi_arready <= ~rvalid_reg & ~ar_take & ~in_reset;
      if (ar_take)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_ok ? GPIOP_RESP_OKAY : GPIOP_RESP_SLVERR;
      end
      else if (rvalid_reg & s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end

  // Pad multiplexer: each pin is owned by the port or its alternate.
  gpiop_drive_t drive_next;
  generate
    for (genvar i = 0; i < PINS; i = i + 1)
    begin : g_pad
      assign drive_next.value[i] = alt_sel_reg[i] ? alt_out[i] : out_reg[i];
      assign drive_next.enable[i] = alt_sel_reg[i] ? alt_oe[i] : oe_reg[i];
    end
  endgenerate

  // Pad outputs are registered; enabled pulls hold undriven pins at their level.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_out <= '0;
      pad_oe <= '0;
      pad_pull_en <= '0;
      pad_pull_up <= '0;
      alt_in <= '0;
      strap_mode <= '0;
      ready <= 1'b0;
    end
    else
    begin
      pad_out <= drive_next.value;
      pad_oe <= in_reset ? '0 : drive_next.enable;
      pad_pull_en <= pull_en_reg;
      pad_pull_up <= pull_up_reg;
      alt_in <= pin_sync;
      strap_mode <= strap_reg;
      ready <= ~in_reset;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule

// >>> src/gpiop_pkg.sv
// Package for the general-purpose I/O port: register map, fields, resets.
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
package gpiop_pkg;

  localparam int GPIOP_PINS = 8;

  // Register byte offsets.
  localparam logic [7:0] GPIOP_OUT_OFS = 8'h00;
  localparam logic [7:0] GPIOP_OE_OFS = 8'h04;
  localparam logic [7:0] GPIOP_PULL_EN_OFS = 8'h08;
  localparam logic [7:0] GPIOP_PULL_UP_OFS = 8'h0c;
  localparam logic [7:0] GPIOP_ALT_SEL_OFS = 8'h10;
  localparam logic [7:0] GPIOP_IN_OFS = 8'h14;
  localparam logic [7:0] GPIOP_STRAP_OFS = 8'h18;
  localparam logic [7:0] GPIOP_STATUS_OFS = 8'h1c;

  // Reset values.
  localparam logic [7:0] GPIOP_OUT_RST = 8'h00;
  localparam logic [7:0] GPIOP_OE_RST = 8'h00;
  localparam logic [7:0] GPIOP_PULL_EN_RST = 8'h00;
  localparam logic [7:0] GPIOP_PULL_UP_RST = 8'h00;
  localparam logic [7:0] GPIOP_ALT_SEL_RST = 8'h00;

  // Status register field positions.
  localparam int GPIOP_STAT_IDLE_BIT = 0;
  localparam int GPIOP_STAT_EXT_BIT = 1;

  // Recommended external power-on reset low time and its cycle count.
  localparam int GPIOP_POR_MS = 50;
  localparam int GPIOP_CLK_HZ = 20000000;
  localparam int GPIOP_POR_CYCLES = GPIOP_POR_MS * (GPIOP_CLK_HZ / 1000);

  // Internal reset stretch after power-up.
  localparam int GPIOP_INT_RST_CYCLES = 16;

  // AXI responses.
  localparam logic [1:0] GPIOP_RESP_OKAY = 2'b00;
  localparam logic [1:0] GPIOP_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    GPIOP_ST_RESET = 2'b00,
    GPIOP_ST_LATCH = 2'b01,
    GPIOP_ST_IDLE = 2'b10
  } gpiop_state_t;

  // Every pad's drive as seen from the port: value and enable vectors.
  typedef struct packed {
    logic [GPIOP_PINS-1:0] value;
    logic [GPIOP_PINS-1:0] enable;
  } gpiop_drive_t;

endpackage

// >>> src/gpiop_sync.sv
// Two-flop synchroniser for a vector of asynchronous inputs.
// Assumes the inputs come from pins outside the clk domain.
`timescale 1ns/100ps
module gpiop_sync
  import gpiop_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// >>> bench/gpiop_pin_model.sv
// Model of the devices and resistors on the eight port pins.
// Assumes the pad drive, enable and pull controls come from the port.
`timescale 1ns/100ps
module gpiop_pin_model
(
  // Clock
  input wire logic clk,
  // Port side
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pull_en,
  input wire logic [7:0] pad_pull_up,
  // Outside drivers
  input wire logic [7:0] ext_drv,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  // A floating pin wanders, so a stale level is never mistaken for data.
  logic [7:0] drift = 8'h55;
  logic [7:0] quiet;
  always @(posedge clk) drift <= ~drift;
  assign quiet = ~pad_oe & ~ext_drv;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_val)
    | (quiet & pad_pull_en & pad_pull_up)
    | (quiet & ~pad_pull_en & drift);
endmodule

// >>> bench/gpiop_top_properties.sv
// Checker for the port: reset, straps, pin sampling and bus answers.
// Assumes it is bound into gpiop_top and sees only its ports.
`timescale 1ns/100ps
module gpiop_top_properties
  import gpiop_pkg::*;
#(
  parameter int PINS = 8
)
(
  // Clock and resets
  input wire logic clk,
  input wire logic resetn,
  input wire logic ext_por_n,
  // Bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Pads
  input wire logic [PINS-1:0] pad_in,
  input wire logic [PINS-1:0] pad_oe,
  input wire logic [PINS-1:0] alt_in,
  input wire logic [PINS-1:0] strap_in,
  input wire logic [PINS-1:0] strap_mode,
  input wire logic ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_tristate;
    !ready |-> ~|pad_oe;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("pad driven before idle");
  property p_ext_override;
    !ext_por_n |-> !ready && ~|pad_oe;
  endproperty
  a_ext_override: assert property (p_ext_override)
    else $error("external reset ignored");
  property p_init_done;
    $rose(resetn && ext_por_n) |-> ##[1:40] ready;
  endproperty
  a_init_done: assert property (p_init_done)
    else $error("idle not reached");
  property p_strap;
    $rose(ready) |-> strap_mode == strap_in;
  endproperty
  a_strap: assert property (p_strap)
    else $error("strap not latched");
  property p_sync;
    (ready && $stable(pad_in)) [*5] |-> alt_in == pad_in;
  endproperty
  a_sync: assert property (p_sync)
    else $error("pin level not passed through");
  property p_bad_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    s_axi_awaddr > 8'h1f |-> ##[1:2] s_axi_bvalid &&
    s_axi_bresp == GPIOP_RESP_SLVERR;
  endproperty
  a_bad_wr: assert property (p_bad_wr)
    else $error("unmapped write not refused");
  property p_bad_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1f |=>
    s_axi_rvalid && s_axi_rresp == GPIOP_RESP_SLVERR;
  endproperty
  a_bad_rd: assert property (p_bad_rd)
    else $error("unmapped read not refused");
  property p_rdata_high;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_rdata_high: assert property (p_rdata_high)
    else $error("read data above pin width");
endmodule
bind gpiop_top gpiop_top_properties #(.PINS(PINS)) u_props (
  .clk(clk), .resetn(resetn), .ext_por_n(ext_por_n),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .pad_in(pad_in), .pad_oe(pad_oe),
  .alt_in(alt_in), .strap_in(strap_in), .strap_mode(strap_mode),
  .ready(ready));

// >>> bench/tb_general_purpose_io_port.sv
// Testbench for the port: bus tasks and pin scenarios.
// Assumes gpiop_top, the pin model and the bound checker.
`timescale 1ns/100ps
`define CHK(n, e, a) \
  cmp_count++; \
  if ((a) !== (e)) \
  begin \
    fails++; \
    $display("[ERR] %s exp %h got %h", n, e, a); \
  end
module tb_general_purpose_io_port;
  import gpiop_pkg::*;
  localparam logic [7:0] STRAP = 8'h5a;
  localparam logic [1:0] OK = GPIOP_RESP_OKAY;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ext_por_n = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] pad_in, pad_out, pad_oe, pad_pull_en, pad_pull_up;
  logic [7:0] alt_in, strap_mode, alt_out = 8'h00, alt_oe = 8'h00;
  logic [7:0] ext_drv = 8'h00, ext_val = 8'h00;
  int fails = 0, cmp_count = 0;
  always #25 clk = ~clk;
  gpiop_top u_dut (
    .clk, .resetn, .ext_por_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out,
    .pad_oe, .pad_pull_en, .pad_pull_up, .alt_out, .alt_oe, .alt_in,
    .strap_in(STRAP), .strap_mode, .ready);
  gpiop_pin_model u_pins (
    .clk, .pad_out, .pad_oe, .pad_pull_en, .pad_pull_up, .ext_drv,
    .ext_val, .pad_in);
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wchk(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK("bresp", e, s_axi_bresp)
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    `CHK("ready", 1'b1, ready)
  endtask
  task automatic t_reset;
    int i;
    `CHK("oe", 8'h00, pad_oe)
    `CHK("strap", STRAP, strap_mode)
    for (i = 0; i < 5; i++)
      rchk(GPIOP_OUT_OFS + 8'(4 * i), 32'h0, OK);
    rchk(GPIOP_STATUS_OFS, 32'h3, OK);
  endtask
  task automatic t_dir;
    ext_drv <= 8'hf0;
    ext_val <= 8'hc0;
    wchk(GPIOP_OUT_OFS, 32'hffffffa5, OK);
    wchk(GPIOP_OE_OFS, 32'h0000000f, OK);
    repeat (4) @(posedge clk);
    `CHK("oe", 8'h0f, pad_oe)
    rchk(GPIOP_OUT_OFS, 32'ha5, OK);
    rchk(GPIOP_IN_OFS, 32'hc5, OK);
  endtask
  task automatic t_pull;
    logic [7:0] v;
    v = 8'h3c;
    ext_drv <= 8'h00;
    wchk(GPIOP_OE_OFS, 32'h0, OK);
    wchk(GPIOP_PULL_EN_OFS, 32'hff, OK);
    repeat (2)
    begin
      wchk(GPIOP_PULL_UP_OFS, {24'h0, v}, OK);
      repeat (4) @(posedge clk);
      `CHK("pull", v, pad_pull_up & pad_pull_en)
      rchk(GPIOP_IN_OFS, {24'h0, v}, OK);
      v = ~v;
    end
  endtask
  task automatic t_alt;
    alt_oe <= 8'h05;
    alt_out <= 8'hff;
    wchk(GPIOP_OE_OFS, 32'h30, OK);
    wchk(GPIOP_ALT_SEL_OFS, 32'h0f, OK);
    repeat (6) @(posedge clk);
    `CHK("mux oe", 8'h35, pad_oe)
    `CHK("mux out", 8'h25, pad_out & pad_oe)
    `CHK("alt in", 8'h07, alt_in & 8'h0f)
  endtask
  task automatic t_bad;
    // A write with byte lane 0 disabled must leave the register alone.
    s_axi_wstrb <= 4'he;
    wchk(GPIOP_OUT_OFS, 32'h0, OK);
    s_axi_wstrb <= 4'hf;
    rchk(GPIOP_OUT_OFS, 32'ha5, OK);
    wchk(8'h40, 32'hff, GPIOP_RESP_SLVERR);
    rchk(8'h40, 32'h0, GPIOP_RESP_SLVERR);
    wchk(GPIOP_STRAP_OFS, 32'h0, OK);
    rchk(GPIOP_STRAP_OFS, {24'h0, STRAP}, OK);
  endtask
  task automatic t_por;
    // The hold is far shorter than advised; the port does not time it.
    ext_por_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("por oe", 8'h00, pad_oe)
    `CHK("por ready", 1'b0, ready)
    ext_por_n <= 1'b1;
    wait_ready;
    rchk(GPIOP_ALT_SEL_OFS, 32'h0, OK);
    rchk(GPIOP_OE_OFS, 32'h0, OK);
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    tally_and_finish;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    wait_ready;
    t_reset;
    t_dir;
    t_pull;
    t_alt;
    t_bad;
    t_por;
    tally_and_finish;
  end
endmodule
